// [rtl/pfs_pkg.sv]
// Constants, types and timing for the paper feed stepper sequencer.
// Assumes one 250 MHz clock and a four-wire bipolar driver.
// Operation
// - Keep the step rate below 3520 steps per second while feeding. The code's shortest period of 284 us allows up to 3521 steps per second.
// - Remove all coil current whenever no feed is in progress.
// - On stopping, hold the last step pattern for 30 ms, then switch off.
// - After the stop hold, leave the windings off while stopped.
// - A feed request during the stop hold ends it and starts stepping at once.
// - Starting from off, apply the hold pattern for 30 ms before stepping.
// - Ramp every mode through the acceleration table to its constant rate.
// - The ramp starts at 2500 us then 1724 us, then the listed periods.
// - Cap the rate at 180, 120, 80, 220 and 80 mm/s by mode.
// - Auto-loading ramps the same table up to its set drive speed.
// - With a presenter fitted the auto-loading feed is 800 steps.
// - The drive rate may be lowered for supply, heat and dot load.
// - Forward feed cycles the four step winding patterns in order.
// - The ramp ends at step 100, 284 us, and never goes beyond it.
package pfs_pkg;
  localparam int CLK_MHZ = 250;
  localparam int HOLD_MS = 30;
  localparam int HOLD_CYC = HOLD_MS * 1000 * CLK_MHZ;
  localparam int HOLD_W = 23;
  localparam int PER_W = 20;
  localparam int TBL_W = 12;
  localparam int IDX_W = 7;
  localparam int CNT_W = 16;
  localparam int TBL_LEN = 100;
  localparam int MIN_PER_US = 284;
  localparam logic [IDX_W-1:0] TOP_LOW = 7'h09;
  localparam logic [IDX_W-1:0] TOP_MIDDLE = 7'h16;
  localparam logic [IDX_W-1:0] TOP_STANDARD = 7'h39;
  localparam logic [IDX_W-1:0] TOP_HIGH = 7'h63;
  localparam logic [CNT_W-1:0] PRESENTER_STEPS = 16'h0320;
  localparam logic [3:0] PAT [4] = '{4'h9, 4'ha, 4'h6, 4'h5};
  typedef enum logic [2:0] {
    PFS_STANDARD, PFS_MIDDLE, PFS_LOW, PFS_HIGH, PFS_TWO_COLOR
  } pfs_mode_t;
endpackage

// [rtl/pfs_tbl_if.sv]
// Carrier between the sequencer and its period table.
// Assumes the table answers one clock after the index is presented.
interface pfs_tbl_if;
  import pfs_pkg::*;
  logic [IDX_W-1:0] idx;
  logic [TBL_W-1:0] per_us;
  modport user (output idx, input per_us);
  modport table_side (input idx, output per_us);
endinterface

// [rtl/pfs_period_rom.sv]
// Acceleration period table, one entry per ramp step, in microseconds.
// Assumes index below the table length; read data are registered.
module pfs_period_rom
  import pfs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  pfs_tbl_if.table_side tb
);
  localparam logic [TBL_W-1:0] ROM [TBL_LEN] = '{
    12'h9c4, 12'h6bc, 12'h57e, 12'h4c4, 12'h445, 12'h3e9, 12'h3a1, 12'h368,
    12'h338, 12'h30f, 12'h2ec, 12'h2cd, 12'h2b3, 12'h29b, 12'h285, 12'h271,
    12'h260, 12'h250, 12'h241, 12'h233, 12'h226, 12'h21b, 12'h20f, 12'h205,
    12'h1fb, 12'h1f2, 12'h1e9, 12'h1e1, 12'h1d9, 12'h1d2, 12'h1cb, 12'h1c5,
    12'h1be, 12'h1b9, 12'h1b3, 12'h1ad, 12'h1a8, 12'h1a3, 12'h19e, 12'h19a,
    12'h195, 12'h191, 12'h18d, 12'h189, 12'h185, 12'h181, 12'h17d, 12'h17a,
    12'h177, 12'h173, 12'h170, 12'h16d, 12'h16a, 12'h167, 12'h165, 12'h162,
    12'h15f, 12'h15d, 12'h15a, 12'h158, 12'h155, 12'h153, 12'h151, 12'h14f,
    12'h14c, 12'h14a, 12'h148, 12'h146, 12'h144, 12'h143, 12'h141, 12'h13f,
    12'h13d, 12'h13c, 12'h13a, 12'h139, 12'h137, 12'h136, 12'h134, 12'h133,
    12'h131, 12'h130, 12'h12f, 12'h12d, 12'h12c, 12'h12b, 12'h12a, 12'h128,
    12'h127, 12'h126, 12'h125, 12'h124, 12'h123, 12'h122, 12'h121, 12'h120,
    12'h11f, 12'h11e, 12'h11d, 12'h11c
  };
  logic [TBL_W-1:0] per_r;
  assign tb.per_us = per_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      per_r <= '0;
    end else begin
      per_r <= ROM[tb.idx];
    end
  end
endmodule

// [rtl/pfs_feed_seq.sv]
// Paper feed stepper sequencer: hold, ramp, constant rate, stop hold.
// Assumes a bipolar constant-current driver taking the four coil levels.
module pfs_feed_seq
  import pfs_pkg::*;
#(
  parameter int HOLD_CYCLES = pfs_pkg::HOLD_CYC,
  parameter int CYC_PER_US = pfs_pkg::CLK_MHZ,
  parameter logic [pfs_pkg::IDX_W-1:0] AUTOLOAD_TOP = 7'h09
)(
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic FEED_REQ,
  input wire logic [pfs_pkg::CNT_W-1:0] FEED_STEPS,
  input wire pfs_pkg::pfs_mode_t MODE,
  input wire logic AUTO_LOAD,
  input wire logic PRESENTER,
  input wire logic [pfs_pkg::IDX_W-1:0] RATE_LIMIT_STEP,
  output logic COIL_A,
  output logic COIL_A_BAR,
  output logic COIL_B,
  output logic COIL_B_BAR,
  output logic DRIVE_EN,
  output logic STEP_PULSE,
  output logic BUSY,
  output logic FEED_DONE
);
  import pfs_pkg::*;

  // Elaboration checks on what the counters can hold
  if (HOLD_CYCLES < 2 || HOLD_CYCLES >= (1 << HOLD_W)) begin
    $error("HOLD_CYCLES out of range");
  end
  if (CYC_PER_US < 1 || CYC_PER_US * 2500 >= (1 << PER_W)) begin
    $error("CYC_PER_US out of range");
  end
  if (AUTOLOAD_TOP >= TBL_LEN) begin
    $error("AUTOLOAD_TOP beyond table");
  end

  typedef enum logic [2:0] {
    ST_IDLE, ST_START_HOLD, ST_WAIT, ST_FETCH, ST_RUN, ST_STOP_HOLD
  } pfs_state_t;

  pfs_state_t state_r, state_nxt;
  logic [HOLD_W-1:0] hold_r, hold_nxt;
  logic [PER_W-1:0] per_r, per_nxt;
  logic [IDX_W-1:0] idx_r, idx_nxt;
  logic [CNT_W-1:0] left_r, left_nxt;
  logic [1:0] phase_r, phase_nxt;
  logic [3:0] coil_r, coil_nxt;
  logic done_r;

  pfs_tbl_if tbl ();
  pfs_period_rom u_rom (.clk(CLOCK), .rst_n(NRST), .tb(tbl.table_side));
  assign tbl.idx = idx_r;

  // Top ramp index: mode cap, optional lower limit from the user
  wire logic [IDX_W-1:0] mode_top =
    AUTO_LOAD ? AUTOLOAD_TOP :
    (MODE == PFS_MIDDLE) ? TOP_MIDDLE :
    (MODE == PFS_HIGH) ? TOP_HIGH :
    (MODE == PFS_STANDARD) ? TOP_STANDARD : TOP_LOW;
  wire logic [IDX_W-1:0] top_idx =
    (RATE_LIMIT_STEP < mode_top) ? RATE_LIMIT_STEP : mode_top;
  wire logic [CNT_W-1:0] req_steps =
    (AUTO_LOAD && PRESENTER) ? PRESENTER_STEPS : FEED_STEPS;
  wire logic req_ok = FEED_REQ && (req_steps != '0);
  wire logic [31:0] per_prod = 32'(tbl.per_us) * 32'(CYC_PER_US) - 32'd3;
  wire logic step_now = (state_r == ST_RUN) && (per_r == '0);
  wire logic hold_end = (hold_r == '0);

  always_comb begin
    state_nxt = state_r;
    hold_nxt = hold_r;
    per_nxt = per_r;
    idx_nxt = idx_r;
    left_nxt = left_r;
    phase_nxt = phase_r;
    case (state_r)
      ST_IDLE: begin
        if (req_ok) begin
          state_nxt = ST_START_HOLD;
          hold_nxt = HOLD_W'(HOLD_CYCLES - 1);
          left_nxt = req_steps;
          idx_nxt = '0;
        end
      end
      ST_START_HOLD: begin
        if (hold_end) begin
          state_nxt = ST_WAIT;
        end else begin
          hold_nxt = hold_r - 1'b1;
        end
      end
      ST_WAIT: begin
        state_nxt = ST_FETCH;
      end
      ST_FETCH: begin
        per_nxt = per_prod[PER_W-1:0];
        state_nxt = ST_RUN;
      end
      ST_RUN: begin
        if (step_now) begin
          phase_nxt = phase_r + 2'd1;
          left_nxt = left_r - 1'b1;
          idx_nxt = (idx_r < top_idx) ? idx_r + 1'b1 : idx_r;
          if (left_r == 16'h0001) begin
            state_nxt = ST_STOP_HOLD;
            hold_nxt = HOLD_W'(HOLD_CYCLES - 1);
          end else begin
            state_nxt = ST_WAIT;
          end
        end else begin
          per_nxt = per_r - 1'b1;
        end
      end
      ST_STOP_HOLD: begin
        if (req_ok) begin
          state_nxt = ST_WAIT;
          left_nxt = req_steps;
          idx_nxt = '0;
        end else if (hold_end) begin
          state_nxt = ST_IDLE;
        end else begin
          hold_nxt = hold_r - 1'b1;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Coils dark whenever idle; detent torque keeps the paper
  assign coil_nxt = (state_nxt == ST_IDLE) ? 4'h0 : PAT[phase_nxt];

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      state_r <= ST_IDLE;
      hold_r <= '0;
      per_r <= '0;
      idx_r <= '0;
      left_r <= '0;
      phase_r <= '0;
      coil_r <= '0;
      done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      hold_r <= hold_nxt;
      per_r <= per_nxt;
      idx_r <= idx_nxt;
      left_r <= left_nxt;
      phase_r <= phase_nxt;
      coil_r <= coil_nxt;
      done_r <= (state_r == ST_STOP_HOLD) && (state_nxt == ST_IDLE);
    end
  end

  assign {COIL_A, COIL_A_BAR, COIL_B, COIL_B_BAR} = coil_r;
  assign DRIVE_EN = (coil_r != 4'h0);
  assign STEP_PULSE = step_now;
  assign BUSY = (state_r != ST_IDLE);
  assign FEED_DONE = done_r;

  // Checking helpers
  localparam int MIN_GAP = MIN_PER_US * CYC_PER_US;
  logic [PER_W-1:0] gap_r;
  logic gap_ok_r;
  logic [HOLD_W-1:0] sh_r;
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      gap_r <= '0;
      gap_ok_r <= 1'b0;
      sh_r <= '0;
    end else begin
      // Saturate so a long stop hold cannot wrap the gap
      gap_r <= step_now ? '0 : (gap_r == '1) ? gap_r : gap_r + 1'b1;
      gap_ok_r <= step_now ? 1'b1 : (gap_ok_r && state_r != ST_IDLE);
      sh_r <= (state_r == ST_STOP_HOLD) ? sh_r + 1'b1 : '0;
    end
  end

  coils_off_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    state_r == ST_IDLE |-> coil_r == 4'h0 && !DRIVE_EN)
    else $error("coils energised while idle");
  rate_cap_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    step_now && gap_ok_r |-> 32'(gap_r) >= 32'(MIN_GAP) - 1)
    else $error("step rate above the limit");
  stop_len_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    state_r == ST_STOP_HOLD ##1 state_r == ST_IDLE && !$past(req_ok)
    |-> 32'(sh_r) == 32'(HOLD_CYCLES))
    else $error("stop hold length wrong");
  hold_pat_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    state_r == ST_STOP_HOLD && $past(state_r) == ST_STOP_HOLD
    |-> $stable(coil_r) && DRIVE_EN)
    else $error("stop hold pattern changed");
  restart_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    state_r == ST_STOP_HOLD && req_ok |=> state_r == ST_WAIT ##2
    state_r == ST_RUN)
    else $error("restart did not skip the hold");
  start_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    state_r == ST_IDLE && req_ok |=> state_r == ST_START_HOLD
    && DRIVE_EN && coil_r == PAT[phase_r])
    else $error("start hold missing");
  first_per_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    state_r == ST_FETCH && idx_r == '0 |=>
    32'(per_r) == 2500 * CYC_PER_US - 3)
    else $error("first ramp period wrong");
  ramp_cap_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    state_r == ST_RUN |-> idx_r < TBL_LEN && (idx_r <= top_idx ||
    $stable(idx_r)))
    else $error("ramp beyond its cap");
  phase_adv_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    step_now |=> phase_r == $past(phase_r) + 2'd1)
    else $error("phase did not advance");
  last_step_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    step_now && left_r == 16'h0001 |=> state_r == ST_STOP_HOLD && left_r == '0)
    else $error("no stop hold after last step");

  feed_done_c: cover property (@(posedge CLOCK) disable iff (!NRST)
    FEED_DONE);
  restart_c: cover property (@(posedge CLOCK) disable iff (!NRST)
    state_r == ST_STOP_HOLD && req_ok);
  presenter_c: cover property (@(posedge CLOCK) disable iff (!NRST)
    state_r == ST_IDLE && req_ok && AUTO_LOAD && PRESENTER);
  top_rate_c: cover property (@(posedge CLOCK) disable iff (!NRST)
    step_now && idx_r == TOP_HIGH);
endmodule

// [verif/pfs_motor_model.sv]
// Stepper motor seen from its four coil lines.
// Assumes coil levels change only just after clk edges.
module pfs_motor_model (
  input wire logic clk,
  input wire logic a,
  input wire logic ab,
  input wire logic b,
  input wire logic bb,
  output int pos,
  output int bad
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] pat;
  logic [3:0] prev_r = 4'h0;
  int pos_r = 0;
  int bad_r = 0;
  assign pat = {a, ab, b, bb};
  assign pos = pos_r;
  assign bad = bad_r;
  function automatic logic [3:0] step_after(input logic [3:0] p);
    case (p)
      4'h9: step_after = 4'ha;
      4'ha: step_after = 4'h6;
      4'h6: step_after = 4'h5;
      default: step_after = 4'h9;
    endcase
  endfunction
  always @(posedge clk) begin
    if (pat != prev_r && pat != 4'h0 && prev_r != 4'h0) begin
      if (pat == step_after(prev_r)) pos_r <= pos_r + 1;
      else bad_r <= bad_r + 1;
    end
    // Unpowered rotor rests on detent torque
    prev_r <= pat;
  end
endmodule

// [verif/paper_feed_stepper_sequencer_tb.sv]
// Bench for the feed sequencer driving a motor model.
// Assumes a short hold and one clock per microsecond.
module paper_feed_stepper_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pfs_pkg::*;
  localparam int HOLD = 20;
  localparam int PER [24] = '{2500, 1724, 1406, 1220, 1093, 1001, 929,
    872, 824, 783, 748, 717, 691, 667, 645, 625, 608, 592, 577, 563, 550,
    539, 527, 517};
  logic CLOCK = 1'b0;
  logic NRST = 1'b0;
  logic FEED_REQ = 1'b0;
  logic [CNT_W-1:0] FEED_STEPS = 16'h0000;
  pfs_mode_t MODE = PFS_STANDARD;
  logic AUTO_LOAD = 1'b0;
  logic PRESENTER = 1'b0;
  logic [IDX_W-1:0] RATE_LIMIT_STEP = 7'h7f;
  logic COIL_A, COIL_A_BAR, COIL_B, COIL_B_BAR;
  logic DRIVE_EN, STEP_PULSE, BUSY, FEED_DONE;
  logic [7:0] outs;
  int fails = 0;
  int num_checks = 0;
  int pos, bad, w;
  int since = 0;
  int last_gap = 0;
  int done_gap = 0;
  int nshort = 0;
  int nlow = 0;
  int nidle_on = 0;
  assign outs = {COIL_A, COIL_A_BAR, COIL_B, COIL_B_BAR, DRIVE_EN,
    STEP_PULSE, BUSY, FEED_DONE};
  pfs_feed_seq #(.HOLD_CYCLES(HOLD), .CYC_PER_US(1)) i_pfs_feed_seq (
    .CLOCK(CLOCK), .NRST(NRST), .FEED_REQ(FEED_REQ),
    .FEED_STEPS(FEED_STEPS), .MODE(MODE), .AUTO_LOAD(AUTO_LOAD),
    .PRESENTER(PRESENTER), .RATE_LIMIT_STEP(RATE_LIMIT_STEP),
    .COIL_A(COIL_A), .COIL_A_BAR(COIL_A_BAR), .COIL_B(COIL_B),
    .COIL_B_BAR(COIL_B_BAR), .DRIVE_EN(DRIVE_EN),
    .STEP_PULSE(STEP_PULSE), .BUSY(BUSY), .FEED_DONE(FEED_DONE));
  pfs_motor_model i_pfs_motor_model (.clk(CLOCK), .a(COIL_A),
    .ab(COIL_A_BAR), .b(COIL_B), .bb(COIL_B_BAR), .pos(pos), .bad(bad));
  initial begin
    forever #2 CLOCK = ~CLOCK;
  end
  // Step spacing and idle drive monitor
  always @(posedge CLOCK) begin
    since <= STEP_PULSE ? 1 : since + 1;
    if (STEP_PULSE) begin
      last_gap <= since;
      if (since < MIN_PER_US) nshort <= nshort + 1;
    end
    if (FEED_DONE) done_gap <= since;
    if (!DRIVE_EN) nlow <= nlow + 1;
    if (NRST && !BUSY && DRIVE_EN) nidle_on <= nidle_on + 1;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic start(input pfs_mode_t m, input int n, input logic al,
                       input logic pr, input logic [6:0] lim);
    @(posedge CLOCK);
    MODE <= m;
    FEED_STEPS <= 16'(n);
    AUTO_LOAD <= al;
    PRESENTER <= pr;
    RATE_LIMIT_STEP <= lim;
    FEED_REQ <= 1'b1;
    @(posedge CLOCK);
    FEED_REQ <= 1'b0;
    #1;
    chk("busy", 1, BUSY);
    chk("drive", 1, DRIVE_EN);
  endtask
  task automatic wait_pulses(input int k);
    int t, n;
    t = 0;
    n = 0;
    w = 0;
    while (n < k && t < 30000) begin
      @(posedge CLOCK);
      #1;
      t++;
      if (STEP_PULSE === 1'b1 && n == 0) w = t;
      if (STEP_PULSE === 1'b1) n++;
    end
    chk("pulses", k, n);
  endtask
  task automatic wait_done();
    int t;
    t = 0;
    while (FEED_DONE !== 1'b1 && t < 30000) begin
      @(posedge CLOCK);
      #1;
      t++;
    end
    chk("done", 1, FEED_DONE);
  endtask
  task automatic s_feed(input pfs_mode_t m, input int n,
                        input logic [6:0] lim, input int cap,
                        input logic al);
    int p0;
    p0 = pos;
    start(m, n, al, 1'b0, lim);
    wait_pulses(n);
    chk("start hold", 1, w >= HOLD + 2498 && w <= HOLD + 2506);
    wait_done();
    chk("last period", PER[n - 1 < cap ? n - 1 : cap], last_gap);
    repeat (40) @(posedge CLOCK);
    #1;
    chk("stop hold", HOLD + 1, done_gap);
    chk("coils off", 0, outs);
    chk("steps moved", n, pos - p0);
  endtask
  task automatic s_restart();
    int l0;
    start(PFS_LOW, 2, 1'b0, 1'b0, 7'h7f);
    wait_pulses(2);
    repeat (5) @(posedge CLOCK);
    l0 = nlow;
    start(PFS_LOW, 1, 1'b0, 1'b0, 7'h7f);
    wait_pulses(1);
    chk("restart at once", 1, w >= 2494 && w <= 2506);
    chk("drive kept", l0, nlow);
    wait_done();
  endtask
  task automatic s_present();
    start(PFS_STANDARD, 3, 1'b1, 1'b1, 7'h7f);
    wait_pulses(12);
    @(posedge CLOCK);
    #1;
    chk("presenter length", 1, BUSY);
    chk("autoload cap", PER[9], last_gap);
    @(posedge CLOCK);
    NRST <= 1'b0;
    #1;
    chk("reset outputs", 0, outs);
    repeat (8) @(posedge CLOCK);
    NRST <= 1'b1;
  endtask
  initial begin
    repeat (8) @(posedge CLOCK);
    NRST <= 1'b1;
    @(posedge CLOCK);
    #1;
    chk("idle outputs", 0, outs);
    s_feed(PFS_LOW, 12, 7'h7f, 9, 1'b0);
    s_feed(PFS_TWO_COLOR, 11, 7'h7f, 9, 1'b0);
    s_feed(PFS_MIDDLE, 24, 7'h7f, 22, 1'b0);
    s_feed(PFS_HIGH, 5, 7'h02, 2, 1'b0);
    s_restart();
    s_present();
    s_feed(PFS_STANDARD, 3, 7'h7f, 57, 1'b0);
    // Auto-loading without presenter keeps the requested count
    s_feed(PFS_HIGH, 3, 7'h7f, 9, 1'b1);
    chk("rate below max", 0, nshort);
    chk("idle drive", 0, nidle_on);
    chk("motor order", 0, bad);
    finish_test();
  end
  initial begin
    repeat (100000) @(posedge CLOCK);
    fails++;
    finish_test();
  end
endmodule
